// File: rbcc_regs.vh
// Constants for the reset, boot mode and clock control block
`ifndef RBCC_REGS_VH
`define RBCC_REGS_VH

// Chip modes
`define MODE_NORMAL 3'h0
`define MODE_NORMAL_XRAM 3'h1
`define MODE_BOOT_XRAM 3'h2
`define MODE_BOOT 3'h3
`define MODE_TEST 3'h4

// Reset sequencer states
`define ST_RESET 2'h0
`define ST_WAIT_LOCK 2'h1
`define ST_RUN 2'h2
`define ST_BROWNOUT 2'h3

// Brownout qualification time in ns (value not given, plain default)
`define BO_QUAL_NS 1000
`define CLK_PERIOD_NS 25
// Lock hold count after brownout recovery
`define BO_LOCK_CLOCKS 4096

// VCO multiplier
`define VCO_MULT 5'h0f

// Output divider K encodings
`define K_SEL_2 3'h0
`define K_SEL_16 3'h1
`define K_SEL_4 3'h2
`define K_SEL_5 3'h3
`define K_SEL_6 3'h4
`define K_SEL_8 3'h5
`define K_SEL_9 3'h6
`define K_SEL_10 3'h7

`endif

// File: clock_divider.v
// Programmable slowdown divider, divides by 1 to 32
`timescale 1ns/10ps
`default_nettype none

module clock_divider #(
    parameter WIDTH = 5
) (
    // Clock and reset
    input wire i_clock,
    input wire i_rst,
    // Control
    input wire [WIDTH-1:0] i_reload,
    // Output
    output reg o_tick
);

    reg [WIDTH-1:0] count_q;

    // Reload value n divides by n+1; tick is one cycle wide
    always @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            count_q <= {WIDTH{1'b0}};
            o_tick <= 1'b0;
        end else if (count_q >= i_reload) begin
            count_q <= {WIDTH{1'b0}};
            o_tick <= 1'b1;
        end else begin
            count_q <= count_q + {{(WIDTH-1){1'b0}}, 1'b1};
            o_tick <= 1'b0;
        end
    end

endmodule // clock_divider

`default_nettype wire

// File: reset_boot_clock_control.v
// Reset sequencing, boot mode selection, brownout and clock control
`timescale 1ns/10ps
`default_nettype none
`include "rbcc_regs.vh"

////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - Hold CPU reset after reset pin release until PLL lock is seen.
// - At reset rising edge, strap high gives normal, low gives bootstrap.
// - Hardware bootstrap also needs transmit pin high at reset release.
// - Transmit pin low with strap low at reset release gives test mode.
// - Software enters bootstrap via loader enable, swap clear, unlock.
// - Software bits 00 normal, 01 normal XRAM, 11 boot XRAM, 10 boot.
// - Brownout active for qualification time with reset pin high resets.
// - Brownout reset ends once detection is clear and PLL stays locked 4096 clocks.
// - Brownout flag sets when enabled; cleared by reset pin or software.
// - All port pins float while brownout persists with reset pin high.
// - Slowdown divider divides PLL clock by 1 to 32 from reload field.
// - Slowdown mode moves system clock source to slowdown divider.
// - VCO is fifteen times oscillator; PLL output is VCO over K.
// - Divider select encodes K as 2,16,4,5,6,8,9,10.
// - Map select set targets mapped SFR area, clear targets standard.
module reset_boot_clock_control #(
    parameter BO_LOCK_CYCLES = `BO_LOCK_CLOCKS,
    parameter REL_WIDTH = 5
) (
    // Clock and reset
    input wire i_clock,
    input wire i_rst,
    // Board pins
    input wire i_reset_n,
    input wire i_boot_strap_pin,
    input wire i_txd_pin,
    // Analog and PLL status
    input wire i_brownout_det,
    input wire i_pll_lock,
    // Software control
    input wire i_brownout_enable,
    input wire i_brownout_flag_clear,
    input wire i_boot_loader_enable_bit,
    input wire i_swap_bit,
    input wire i_unlock,
    input wire i_slowdown_mode,
    input wire [REL_WIDTH-1:0] i_slowdown_reload_field,
    input wire [2:0] i_k_select,
    input wire i_sfr_map_select,
    // Outputs
    output reg o_cpu_reset,
    output reg [2:0] o_chip_mode,
    output reg o_brownout_flag,
    output reg o_ports_tristate,
    output reg o_sys_tick,
    output reg o_clock_from_slowdown,
    output reg [4:0] o_pll_k,
    output reg [4:0] o_vco_mult,
    output reg o_sfr_mapped
);

    // Least qualification time rounds up
    localparam QUAL_CYCLES =
        (`BO_QUAL_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;

    reg [1:0] state_q;
    reg reset_n_q;
    reg [12:0] bo_cnt_q;
    reg [12:0] lock_cnt_q;
    reg sel_slow_q;
    wire slow_tick;

    // Decode of the divider select
    function [4:0] k_factor;
        input [2:0] sel;
        begin
            case (sel)
                `K_SEL_2: k_factor = 5'd2;
                `K_SEL_16: k_factor = 5'd16;
                `K_SEL_4: k_factor = 5'd4;
                `K_SEL_5: k_factor = 5'd5;
                `K_SEL_6: k_factor = 5'd6;
                `K_SEL_8: k_factor = 5'd8;
                `K_SEL_9: k_factor = 5'd9;
                default: k_factor = 5'd10;
            endcase
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Reset sequencer and brownout

    always @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            state_q <= `ST_RESET;
            reset_n_q <= 1'b0;
            bo_cnt_q <= 13'h0;
            lock_cnt_q <= 13'h0;
            o_cpu_reset <= 1'b1;
            o_chip_mode <= `MODE_NORMAL;
            o_brownout_flag <= 1'b0;
            o_ports_tristate <= 1'b0;
        end else begin
            reset_n_q <= i_reset_n;
            // Brownout qualification counter
            if (i_brownout_det && i_reset_n)
                bo_cnt_q <= (bo_cnt_q < QUAL_CYCLES[12:0]) ?
                    bo_cnt_q + 13'h1 : bo_cnt_q;
            else
                bo_cnt_q <= 13'h0;
            // Set wins over software clear; the pin clears
            if (!i_reset_n)
                o_brownout_flag <= 1'b0;
            else if (i_brownout_det && i_brownout_enable)
                o_brownout_flag <= 1'b1;
            else if (i_brownout_flag_clear)
                o_brownout_flag <= 1'b0;
            o_ports_tristate <= i_reset_n && i_brownout_det;
            case (state_q)
                `ST_RESET: begin
                    o_cpu_reset <= 1'b1;
                    if (i_reset_n && !reset_n_q) begin
                        // Strap sampled only at the release edge
                        if (i_boot_strap_pin)
                            o_chip_mode <= `MODE_NORMAL;
                        else if (i_txd_pin)
                            o_chip_mode <= `MODE_BOOT;
                        else
                            o_chip_mode <= `MODE_TEST;
                        state_q <= `ST_WAIT_LOCK;
                    end
                end
                `ST_WAIT_LOCK: begin
                    if (!i_reset_n)
                        state_q <= `ST_RESET;
                    else if (i_pll_lock) begin
                        o_cpu_reset <= 1'b0;
                        state_q <= `ST_RUN;
                    end
                end
                `ST_RUN: begin
                    if (!i_reset_n) begin
                        o_cpu_reset <= 1'b1;
                        state_q <= `ST_RESET;
                    end else if (bo_cnt_q >= QUAL_CYCLES[12:0]) begin
                        o_cpu_reset <= 1'b1;
                        lock_cnt_q <= 13'h0;
                        state_q <= `ST_BROWNOUT;
                    end else if (i_unlock) begin
                        // Software chip mode change
                        case ({i_boot_loader_enable_bit, i_swap_bit})
                            2'b00: o_chip_mode <= `MODE_NORMAL;
                            2'b01: o_chip_mode <= `MODE_NORMAL_XRAM;
                            2'b11: o_chip_mode <= `MODE_BOOT_XRAM;
                            default: o_chip_mode <= `MODE_BOOT;
                        endcase
                    end
                end
                `ST_BROWNOUT: begin
                    o_cpu_reset <= 1'b1;
                    if (!i_reset_n)
                        state_q <= `ST_RESET;
                    else if (i_brownout_det || !i_pll_lock)
                        lock_cnt_q <= 13'h0;
                    else if (lock_cnt_q >= BO_LOCK_CYCLES[12:0] - 13'h1) begin
                        o_cpu_reset <= 1'b0;
                        state_q <= `ST_RUN;
                    end else
                        lock_cnt_q <= lock_cnt_q + 13'h1;
                end
                default: state_q <= `ST_RESET;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Clock generation control

    clock_divider #(
        .WIDTH(REL_WIDTH)
    ) u_slowdown (
        .i_clock(i_clock),
        .i_rst(i_rst),
        .i_reload(i_slowdown_reload_field),
        .o_tick(slow_tick)
    );

    // Source changes only at a divider boundary so no pulse is cut short
    always @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            sel_slow_q <= 1'b0;
            o_sys_tick <= 1'b0;
            o_clock_from_slowdown <= 1'b0;
            o_pll_k <= 5'd2;
            o_vco_mult <= 5'd0;
            o_sfr_mapped <= 1'b0;
        end else begin
            if (slow_tick)
                sel_slow_q <= i_slowdown_mode;
            o_clock_from_slowdown <= sel_slow_q;
            o_sys_tick <= sel_slow_q ? slow_tick : 1'b1;
            o_pll_k <= k_factor(i_k_select);
            o_vco_mult <= `VCO_MULT;
            o_sfr_mapped <= i_sfr_map_select;
        end
    end

endmodule // reset_boot_clock_control

`default_nettype wire

// File: rbcc_monitor.sv
// Port-level checker for the reset, boot and clock control block
`timescale 1ns/10ps
`default_nettype none
`include "rbcc_regs.vh"
////////////////////////////////////////////////////////////////////////////////
module rbcc_monitor (
    // Clock, reset and pins
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic i_reset_n,
    input wire logic i_boot_strap_pin,
    input wire logic i_txd_pin,
    input wire logic i_brownout_det,
    input wire logic i_pll_lock,
    input wire logic i_boot_loader_enable_bit,
    input wire logic i_swap_bit,
    input wire logic i_unlock,
    // Outputs watched
    input wire logic o_cpu_reset,
    input wire logic [2:0] o_chip_mode,
    input wire logic o_ports_tristate,
    input wire logic o_sys_tick,
    input wire logic o_clock_from_slowdown,
    input wire logic [4:0] o_vco_mult
);
default clocking @(posedge i_clock); endclocking
default disable iff (i_rst);
// Txd only matters when the strap asks for the loader
sequence s_release(strap, txd);
    $rose(i_reset_n) && i_boot_strap_pin == strap &&
        (strap || i_txd_pin == txd);
endsequence
a_reset_hold: assert property (!i_reset_n |=> o_cpu_reset)
    else $error("cpu left reset while pin low");
a_lock_gate: assert property ($fell(o_cpu_reset) |-> $past(i_pll_lock))
    else $error("cpu released without lock");
a_strap_normal: assert property (
    s_release(1, 1) |=> o_chip_mode == `MODE_NORMAL)
    else $error("strap high did not give normal");
a_strap_boot: assert property (
    s_release(0, 1) |=> o_chip_mode == `MODE_BOOT)
    else $error("strap low did not give loader");
a_strap_test: assert property (
    s_release(0, 0) |=> o_chip_mode == `MODE_TEST)
    else $error("txd low did not give test");
// A qualified brownout in the same cycle rightly beats the unlock
a_sw_mode: assert property (
    !o_cpu_reset && i_reset_n && i_unlock && !$past(i_brownout_det) |=>
    o_chip_mode == ($past(i_boot_loader_enable_bit) ?
    3'h3 - {2'h0, $past(i_swap_bit)} : {2'h0, $past(i_swap_bit)}))
    else $error("unlock gave wrong mode");
a_ports_float: assert property (
    i_brownout_det && i_reset_n |=> o_ports_tristate)
    else $error("ports driven in brownout");
// The source may only change right after a whole tick
a_clock_switch: assert property (
    $changed(o_clock_from_slowdown) |-> $past(o_sys_tick))
    else $error("clock source switched mid period");
a_vco_mult: assert property (!$past(i_rst) |-> o_vco_mult == 5'h0f)
    else $error("vco multiplier wrong");
endmodule // rbcc_monitor
bind reset_boot_clock_control rbcc_monitor mon_u (.*);
`default_nettype wire

// File: board_model.sv
// Board reset circuit, strap pulls and crystal with PLL lock
`timescale 1ns/10ps
`default_nettype none
module board_model #(parameter int LOCK_DLY = 4) (
    // Bench requests
    input wire logic i_clock,
    input wire logic i_hold_reset,
    input wire logic i_strap_low,
    input wire logic i_txd_low,
    // Pins
    output logic o_reset_n,
    output logic o_strap,
    output logic o_txd,
    output logic o_pll_lock
);
logic [3:0] cnt_q;
assign o_reset_n = !i_hold_reset;
assign o_strap = !i_strap_low;
assign o_txd = !i_txd_low;
// Lock is lost in reset, so release always waits on a real relock
assign o_pll_lock = cnt_q == 4'(LOCK_DLY);
always @(posedge i_clock) begin
    if (!o_reset_n) cnt_q <= 4'h0;
    else if (!o_pll_lock) cnt_q <= cnt_q + 4'h1;
end
endmodule // board_model
`default_nettype wire

// File: reset_boot_clock_control_tb.sv
// Self-checking bench for the reset, boot and clock control block
`timescale 1ns/10ps
`default_nettype none
`include "rbcc_regs.vh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin err_total++; \
    $display("Error t=%0t got %h exp %h", $time, g, e); end end
module reset_boot_clock_control_tb;
logic i_clock, i_rst, hold, s_low, t_low, rst_n, strap, txd, lock, det, bo_en;
logic bo_clr, bsl, swap, unlock, slow, map, cpu_rst, flag, tri_st, tick, fslow;
logic mapped;
logic [2:0] ksel, mode;
logic [4:0] slowdown_reload_field, pll_k;
logic [3:0] q_sel[$];
logic [7:0] q_val[$];
logic [7:0] k_tab[8] = '{8'h02, 8'h10, 8'h04, 8'h05, 8'h06, 8'h08,
    8'h09, 8'h0a};
logic [2:0] k_ok[5] = '{3'h1, 3'h2, 3'h4, 3'h5, 3'h7};
int err_total, n_tests, ticks, seed = 32'h24bd9288;
board_model brd_u (.i_clock(i_clock), .i_hold_reset(hold),
    .i_strap_low(s_low), .i_txd_low(t_low), .o_reset_n(rst_n),
    .o_strap(strap), .o_txd(txd), .o_pll_lock(lock));
reset_boot_clock_control #(.BO_LOCK_CYCLES(8)) dut_u (.i_clock(i_clock),
    .i_rst(i_rst), .i_reset_n(rst_n), .i_boot_strap_pin(strap),
    .i_txd_pin(txd), .i_brownout_det(det), .i_pll_lock(lock),
    .i_brownout_enable(bo_en), .i_brownout_flag_clear(bo_clr),
    .i_boot_loader_enable_bit(bsl), .i_swap_bit(swap), .i_unlock(unlock),
    .i_slowdown_mode(slow), .i_slowdown_reload_field(slowdown_reload_field),
    .i_k_select(ksel), .i_sfr_map_select(map), .o_cpu_reset(cpu_rst),
    .o_chip_mode(mode), .o_brownout_flag(flag), .o_ports_tristate(tri_st),
    .o_sys_tick(tick), .o_clock_from_slowdown(fslow), .o_pll_k(pll_k),
    .o_vco_mult(), .o_sfr_mapped(mapped));
////////////////////////////////////////////////////////////////////////////////
function automatic logic [7:0] got(input logic [3:0] s);
    logic [7:0] v [8];
    v = '{{5'h0, mode}, {7'h0, cpu_rst}, {3'h0, pll_k}, {7'h0, flag},
        {7'h0, tri_st}, {7'h0, mapped}, {7'h0, fslow}, 8'(ticks)};
    return v[s[2:0]];
endfunction
task automatic want(input logic [3:0] s, input logic [7:0] v);
    q_sel.push_back(s);
    q_val.push_back(v);
endtask
task automatic end_of_test;
    $display("Checks %0d, errors %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
endtask
// Notes queued at a falling edge are judged after the next rising edge
always @(posedge i_clock) begin : watch
    logic [7:0] g, e;
    #2;
    while (q_sel.size() > 0) begin
        g = got(q_sel.pop_front());
        e = q_val.pop_front();
        `CHK(g, e)
    end
end
task automatic boot(input logic sl, input logic tl, input logic [2:0] m);
    @(negedge i_clock);
    {hold, s_low, t_low} = {1'b1, sl, tl};
    repeat (3) @(negedge i_clock);
    hold = 0;
    want(0, {5'h0, m});
    want(1, 8'h1);
    @(negedge i_clock);
    // Straps move after release; the latched mode must not follow
    {s_low, t_low} = {!sl, 1'b0};
    repeat (7) @(negedge i_clock);
    want(0, {5'h0, m});
    want(1, 8'h0);
endtask
initial begin
    i_clock = 0;
    forever #12.5 i_clock = ~i_clock;
end
initial begin
    #125000;
    err_total++;
    end_of_test;
end
initial begin
    {i_rst, hold, s_low, t_low, det, bo_en, bo_clr, bsl, swap} = 9'h180;
    {unlock, slow, map, ksel, slowdown_reload_field, ticks} = '0;
    repeat (6) @(negedge i_clock);
    i_rst = 0;
    boot(1'b0, 1'b0, `MODE_NORMAL);
    boot(1'b1, 1'b0, `MODE_BOOT);
    boot(1'b1, 1'b1, `MODE_TEST);
    boot(1'b0, 1'b1, `MODE_NORMAL);
    for (int i = 0; i < 4; i++) begin
        @(negedge i_clock);
        {bsl, swap, unlock} = {i[1:0], 1'b1};
        want(0, 8'(i[1] ? 3 - i[0] : i[0]));
    end
    repeat (8) begin
        @(negedge i_clock);
        unlock = 0;
        // Only even factors that keep the CPU at or below 40 MHz
        ksel = k_ok[$unsigned($random(seed)) % 5];
        map = 1'($random(seed));
        want(2, k_tab[ksel]);
        want(5, {7'h0, map});
    end
    slowdown_reload_field = 5'($random(seed));
    slow = 1;
    repeat (70) @(negedge i_clock);
    want(6, 8'h1);
    repeat (4 * (slowdown_reload_field + 1)) @(negedge i_clock) ticks += tick;
    want(7, 8'h4);
    slow = 0;
    repeat (70) @(negedge i_clock);
    want(6, 8'h0);
    // First cycle with detection disabled must leave the flag alone
    det = 1;
    want(3, 8'h0);
    want(4, 8'h1);
    @(negedge i_clock);
    bo_en = 1;
    repeat (38) @(negedge i_clock);
    want(1, 8'h0);
    @(negedge i_clock);
    want(1, 8'h1);
    want(3, 8'h1);
    repeat (5) @(negedge i_clock);
    det = 0;
    repeat (6) @(negedge i_clock);
    want(1, 8'h1);
    @(negedge i_clock);
    want(1, 8'h0);
    bo_clr = 1;
    want(3, 8'h0);
    repeat (3) @(negedge i_clock);
    end_of_test;
end
endmodule // reset_boot_clock_control_tb
`default_nettype wire
